// file: dv/post_divider_frame_pulse_tb.sv
`timescale 1ns/100ps
`default_nettype none
module post_divider_frame_pulse_tb;
    import pfp_pkg::*;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    wr_s        wr = '0;
    logic [7:0] rd_addr = 8'h00;
    logic       route = 1'b0;
    related_s   rel;
    logic [7:0] rd_data;
    logic       div_out;
    int         miscompares = 0;
    int         check_count = 0;

    always #12.5 clk = ~clk;

    sib_clk_model sib_clk_model_inst (.clk(clk), .rstn(rstn), .rel(rel));
    post_divider_frame_pulse post_divider_frame_pulse_inst (
        .REF_CLK(clk), .RSTN(rstn), .REG_WR(wr), .REG_RD_ADDR(rd_addr),
        .RELATED(rel), .ROUTE_TO_CFG_PINS(route),
        .REG_RD_DATA(rd_data), .DIV_OUT(div_out));

    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic step(inout int g);
        tick();
        g++;
    endtask

    task automatic chk(input logic [31:0] got, exp, input string m);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %0h exp %0h",
                     $time, m, got, exp);
        end
    endtask

    task automatic wr8(input logic [7:0] a, d);
        tick();
        wr = '{1'b1, a, d};
        tick();
        wr.en = 1'b0;
    endtask

    task automatic set(input logic [23:0] w);
        wr8(CTRL_ADDR_LO, w[7:0]);
        wr8(CTRL_ADDR_MID, w[15:8]);
        wr8(CTRL_ADDR_HI, w[23:16]);
    endtask

    task automatic rd(input logic [7:0] a, exp);
        tick();
        rd_addr = a;
        tick();
        chk(rd_data, exp, "read");
    endtask

    // Bounded waits: a stuck output shows up as a wrong count, not a hang
    task automatic meas(input logic act, output int on, off,
                        output related_s x);
        int g, g0;
        g = 0;
        while (div_out === act && g < 3000) step(g);
        while (div_out !== act && g < 3000) step(g);
        x = rel;
        g0 = g;
        while (div_out === act && g < 3000) step(g);
        on = g - g0;
        g0 = g;
        while (div_out !== act && g < 3000) step(g);
        off = g - g0;
    endtask

    task automatic t_regs;
        rd(CTRL_ADDR_LO, 8'h40);
        rd(CTRL_ADDR_MID, 8'h00);
        rd(CTRL_ADDR_HI, 8'h00);
        wr8(8'h89, 8'h5a);
        rd(8'h89, 8'h00);
        wr8(CTRL_ADDR_MID, 8'ha5);
        rd(CTRL_ADDR_MID, 8'ha5);
        wr8(CTRL_ADDR_MID, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_restart;
        int g, on, off;
        related_s x;
        g = 0;
        while (div_out !== 1'b1 && g < 200) step(g);
        tick(4);
        wr8(CTRL_ADDR_LO, 8'h08);
        g = 0;
        while (div_out !== 1'b0 && g < 3) step(g);
        chk(div_out, 1'b0, "restart idle");
        meas(1'b1, on, off, x);
        chk(on, 4, "first high");
        chk(off, 4, "first low");
        $display("test restart done");
    endtask

    task automatic t_clock;
        int r[5] = '{2, 7, 8, 41, 0};
        int on, off, q;
        related_s x;
        foreach (r[i]) begin
            set(r[i][23:0]);
            meas(1'b1, on, off, x);
            q = (r[i] < 2) ? 2 : r[i];
            chk(on, (q + 1) / 2, "high phase");
            chk(off, q / 2, "low phase");
        end
        $display("test clock done");
    endtask

    task automatic frame(input logic [1:0] s, input logic p, rt, ty,
                         input logic [15:0] n, input int w);
        int on, off;
        related_s x;
        logic act, lvl;
        route = rt;
        set({FRAME_MODE_CODE, ty, p, s, n});
        act = ~(p ^ rt);
        meas(act, on, off, x);
        lvl = (s == SEL_A) ? x.clk_a : (s == SEL_B) ? x.clk_b : x.clk_d;
        chk(on, w, "pulse width");
        chk(off, w * (n - 1), "pulse gap");
        chk(lvl, ty, "boundary phase");
        $display("test frame done");
    endtask

    task automatic t_rsvd;
        int bad;
        route = 1'b0;
        set({FRAME_MODE_CODE, 1'b1, 1'b1, SEL_RSVD, 16'h0002});
        tick(3);
        bad = 0;
        repeat (60) begin
            tick();
            bad += (div_out !== 1'b1);
        end
        chk(bad, 0, "reserved selector");
        $display("test reserved done");
    endtask

    task automatic conclude;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        tick(4);
        chk(div_out, 1'b0, "reset level");
        rstn = 1'b1;
        t_regs();
        t_restart();
        t_clock();
        frame(SEL_A, 1'b0, 1'b0, 1'b1, 16'd3, 8);
        frame(SEL_A, 1'b0, 1'b0, 1'b0, 16'd3, 8);
        frame(SEL_B, 1'b1, 1'b0, 1'b1, 16'd2, 12);
        frame(SEL_D, 1'b0, 1'b1, 1'b1, 16'd3, 10);
        frame(SEL_D, 1'b1, 1'b1, 1'b0, 16'd3, 10);
        t_rsvd();
        conclude();
    end

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        conclude();
    end
endmodule
`default_nettype wire

// file: dv/sib_clk_model.sv
`timescale 1ns/100ps
`default_nettype none
module sib_clk_model (
    input  wire logic              clk,
    input  wire logic              rstn,
    output var pfp_pkg::related_s  rel
);
    int n = 0;

    initial rel = '0;

    // Siblings run from the same VCO; they move a little after each edge
    always @(posedge clk) begin
        n <= rstn ? n + 1 : 0;
        rel <= #3 '{(n % 8) < 4, (n % 12) < 6, (n % 10) < 5};
    end
endmodule
`default_nettype wire

// file: rtl/ctrl_regs.sv
`timescale 1ns/100ps
`default_nettype none
module ctrl_regs (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire pfp_pkg::wr_s  wr,
    input  wire logic [7:0]    rd_addr,
    output pfp_pkg::ctrl_s     ctrl,
    output logic [7:0]         rd_data,
    output logic               rewrite
);
    import pfp_pkg::*;

    logic [23:0] word;
    logic [23:0] next_word;
    logic [7:0]  next_rd_data;
    logic        next_rewrite;

    always_comb begin
        next_word    = word;
        next_rewrite = 1'b0;
        if (wr.en) begin
            unique case (wr.addr)
                CTRL_ADDR_LO: begin
                    next_word[7:0] = wr.data;
                    next_rewrite   = 1'b1;
                end
                CTRL_ADDR_MID: begin
                    next_word[15:8] = wr.data;
                    next_rewrite    = 1'b1;
                end
                CTRL_ADDR_HI: begin
                    next_word[23:16] = wr.data;
                    next_rewrite     = 1'b1;
                end
                default: ;
            endcase
        end
        unique case (rd_addr)
            CTRL_ADDR_LO:  next_rd_data = word[7:0];
            CTRL_ADDR_MID: next_rd_data = word[15:8];
            CTRL_ADDR_HI:  next_rd_data = word[23:16];
            default:       next_rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            word    <= CTRL_RESET;
            rd_data <= 8'h00;
            rewrite <= 1'b0;
        end else begin
            word    <= next_word;
            rd_data <= next_rd_data;
            rewrite <= next_rewrite;
        end
    end

    assign ctrl = ctrl_s'(word);

endmodule
`default_nettype wire

// file: rtl/pfp_pkg.sv
package pfp_pkg;

    // Byte addresses of the three bytes of the channel C control word
    localparam logic [7:0]  CTRL_ADDR_LO    = 8'h86;
    localparam logic [7:0]  CTRL_ADDR_MID   = 8'h87;
    localparam logic [7:0]  CTRL_ADDR_HI    = 8'h88;
    localparam logic [23:0] CTRL_RESET      = 24'h000040;

    localparam logic [3:0]  FRAME_MODE_CODE = 4'hf;
    localparam logic [23:0] MAX_RATIO       = 24'hefffff;
    localparam logic [23:0] MIN_RATIO       = 24'h000002;
    localparam logic [15:0] MIN_PERIOD      = 16'h0001;

    localparam logic [1:0]  SEL_A           = 2'h0;
    localparam logic [1:0]  SEL_B           = 2'h1;
    localparam logic [1:0]  SEL_RSVD        = 2'h2;
    localparam logic [1:0]  SEL_D           = 2'h3;

    // Field layout of the control word, most significant field first
    typedef struct packed {
        logic [3:0]  mode;
        logic        frame_type;
        logic        polarity;
        logic [1:0]  rel_sel;
        logic [15:0] period;
    } ctrl_s;

    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } wr_s;

    typedef struct packed {
        logic clk_a;
        logic clk_b;
        logic clk_d;
    } related_s;

    typedef enum logic [2:0] {
        ST_RESTART = 3'b001,
        ST_CLOCK   = 3'b010,
        ST_FRAME   = 3'b100
    } state_e;

endpackage

// file: rtl/post_divider_frame_pulse.sv
// Behaviour
// - Mode field all ones selects frame pulse output instead of divided clock.
// - Otherwise whole 24-bit word divides the clock, about 50% duty.
// - Low sixteen bits count related-clock periods between frame pulses.
// - Selector picks related clock A, B or D; pulse lasts one period.
// - Polarity bit zero gives normal pulse, one gives inverted pulse.
// - Routing to configurable pins reverses the pulse polarity once more.
// - Type zero centres pulse on boundary; type one starts it there.
// - Even ratios give near 50% duty; odd ratios high one extra cycle.
`timescale 1ns/100ps
`default_nettype none
module post_divider_frame_pulse (
    input  wire logic              REF_CLK,
    input  wire logic              RSTN,
    input  wire pfp_pkg::wr_s      REG_WR,
    input  wire logic [7:0]        REG_RD_ADDR,
    input  wire pfp_pkg::related_s RELATED,
    input  wire logic              ROUTE_TO_CFG_PINS,
    output logic [7:0]             REG_RD_DATA,
    output logic                   DIV_OUT
);
    import pfp_pkg::*;

    ctrl_s       ctrl;
    logic        rewrite;
    state_e      state;
    state_e      next_state;
    logic [23:0] cnt;
    logic [23:0] next_cnt;
    logic [15:0] fcnt;
    logic [15:0] next_fcnt;
    logic        pulse;
    logic        next_pulse;
    logic        rel_prev;
    logic        next_rel_prev;
    logic        next_out;
    logic        rel;
    logic        rise;
    logic        fall;
    logic        frame_mode;
    logic [23:0] eff_ratio;
    logic [23:0] half_hi;
    logic [15:0] eff_period;
    logic [15:0] last_period;

    ctrl_regs ctrl_regs_inst (
        .clk     (REF_CLK),
        .rstn    (RSTN),
        .wr      (REG_WR),
        .rd_addr (REG_RD_ADDR),
        .ctrl    (ctrl),
        .rd_data (REG_RD_DATA),
        .rewrite (rewrite)
    );

    assign frame_mode = (ctrl.mode == FRAME_MODE_CODE);
    // Ratios below two cannot be made on one clock edge; run them as two
    assign eff_ratio  = (ctrl_s'(ctrl) < MIN_RATIO) ? MIN_RATIO
                                                   : 24'(ctrl);
    // Odd ratios stay high the extra cycle
    assign half_hi    = eff_ratio - (eff_ratio >> 1);
    assign eff_period = (ctrl.period < MIN_PERIOD) ? MIN_PERIOD
                                                  : ctrl.period;
    assign last_period = eff_period - MIN_PERIOD;

    // Reserved selector code has no source, so no edges and no pulse
    always_comb begin
        unique case (ctrl.rel_sel)
            SEL_A:   rel = RELATED.clk_a;
            SEL_B:   rel = RELATED.clk_b;
            SEL_D:   rel = RELATED.clk_d;
            default: rel = 1'b0;
        endcase
    end
    assign rise = rel & ~rel_prev;
    assign fall = ~rel & rel_prev;

    always_comb begin
        next_state    = state;
        next_cnt      = cnt;
        next_fcnt     = fcnt;
        next_pulse    = pulse;
        next_rel_prev = rel;
        next_out      = DIV_OUT;
        unique case (state)
            ST_RESTART: begin
                // Hold idle one cycle so no partial level leaks out
                next_cnt   = 24'h000000;
                next_fcnt  = 16'h0000;
                next_pulse = 1'b0;
                next_state = frame_mode ? ST_FRAME : ST_CLOCK;
                next_out   = frame_mode
                           & (ctrl.polarity ^ ROUTE_TO_CFG_PINS);
            end
            ST_CLOCK: begin
                next_cnt = (cnt >= eff_ratio - 24'h000001) ? 24'h000000
                                                          : cnt + 24'h000001;
                // Level follows the count just left, so the first high
                // phase after a restart is as long as every later one
                next_out = (cnt < half_hi);
            end
            ST_FRAME: begin
                if (rise) begin
                    next_fcnt = (fcnt >= last_period) ? 16'h0000
                                                      : fcnt + 16'h0001;
                    if (ctrl.frame_type) begin
                        next_pulse = (next_fcnt == 16'h0000);
                    end
                end
                if (fall && !ctrl.frame_type) begin
                    next_pulse = (fcnt == last_period);
                end
                next_out = next_pulse ^ ctrl.polarity
                         ^ ROUTE_TO_CFG_PINS;
            end
        endcase
        if (rewrite) begin
            next_state = ST_RESTART;
            // The old branch already sees the new word; hold the level
            // so that no one-cycle sliver of it reaches the pin
            next_out   = DIV_OUT;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            state    <= ST_RESTART;
            cnt      <= 24'h000000;
            fcnt     <= 16'h0000;
            pulse    <= 1'b0;
            rel_prev <= 1'b0;
            DIV_OUT  <= 1'b0;
        end else begin
            state    <= next_state;
            cnt      <= next_cnt;
            fcnt     <= next_fcnt;
            pulse    <= next_pulse;
            rel_prev <= next_rel_prev;
            DIV_OUT  <= next_out;
        end
    end

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RSTN);

    property p_frame_entry;
        (state == ST_RESTART && !rewrite && frame_mode) |=> state == ST_FRAME;
    endproperty
    a_frame_entry: assert property (p_frame_entry)
        else $error("frame mode code did not lead to frame state");

    property p_clock_wrap;
        (state == ST_CLOCK && !rewrite && cnt == eff_ratio - 24'h000001)
            |=> cnt == 24'h000000;
    endproperty
    a_clock_wrap: assert property (p_clock_wrap)
        else $error("divider did not wrap at the programmed ratio");

    property p_duty;
        (state == ST_CLOCK && $past(state) == ST_CLOCK && !$past(rewrite))
            |-> DIV_OUT == ($past(cnt) < $past(half_hi));
    endproperty
    a_duty: assert property (p_duty)
        else $error("divided clock level does not match duty split");

    property p_frame_wrap;
        (state == ST_FRAME && !rewrite && rise && fcnt == last_period)
            |=> fcnt == 16'h0000;
    endproperty
    a_frame_wrap: assert property (p_frame_wrap)
        else $error("frame period count did not wrap");

    property p_rsvd_quiet;
        (state == ST_FRAME && !rewrite && ctrl.rel_sel == SEL_RSVD)
            |=> $stable(pulse) && $stable(fcnt);
    endproperty
    a_rsvd_quiet: assert property (p_rsvd_quiet)
        else $error("reserved selector produced activity");

    property p_out_polarity;
        (state == ST_FRAME && !rewrite) |=> DIV_OUT == (pulse
            ^ $past(ctrl.polarity) ^ $past(ROUTE_TO_CFG_PINS));
    endproperty
    a_out_polarity: assert property (p_out_polarity)
        else $error("frame pulse output polarity wrong");

    property p_type_edge;
        (state == ST_FRAME && !rewrite && ctrl.frame_type && rise
            && fcnt == last_period) |=> pulse;
    endproperty
    a_type_edge: assert property (p_type_edge)
        else $error("edge type pulse missing at boundary");

    property p_type_mid;
        (state == ST_FRAME && !rewrite && !ctrl.frame_type && fall
            && fcnt == last_period) |=> pulse;
    endproperty
    a_type_mid: assert property (p_type_mid)
        else $error("centred pulse missing before boundary");

    property p_restart;
        rewrite |=> state == ST_RESTART ##1 (cnt == 24'h000000 && !pulse);
    endproperty
    a_restart: assert property (p_restart)
        else $error("rewrite did not restart the output");

    property p_rewrite_hold;
        rewrite |=> DIV_OUT == $past(DIV_OUT);
    endproperty
    a_rewrite_hold: assert property (p_rewrite_hold)
        else $error("output moved in the cycle of a rewrite");

    property p_restart_level;
        (state == ST_RESTART && !rewrite) |=> DIV_OUT == ($past(frame_mode)
            & ($past(ctrl.polarity) ^ $past(ROUTE_TO_CFG_PINS)));
    endproperty
    a_restart_level: assert property (p_restart_level)
        else $error("restart cycle did not give the idle level");

    property p_count_range;
        (state == ST_CLOCK && !rewrite) |-> cnt < eff_ratio;
    endproperty
    a_count_range: assert property (p_count_range)
        else $error("divider count left the programmed ratio");

endmodule
`default_nettype wire
